// *** design/buck_fault_pkg.sv ***
// constants, tables and types of the buck fault supervisor
package buck_fault_pkg;

	// ------------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int NS_PER_US = 1000;
	localparam int OV_DEGLITCH_NS = 1000;
	localparam int UV_DEGLITCH_NS = 3000;
	localparam int SOC_DEGLITCH_NS = 1000;
	localparam int OTP_DEGLITCH_NS = 45000;
	localparam int NVP_HOLD_NS = 45000;
	localparam int DROOP_RETURN_NS = 100000;
	localparam int TICK_US_NS = 1000;
	localparam int OV_DEGLITCH_CYC = (OV_DEGLITCH_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
	localparam int UV_DEGLITCH_CYC = (UV_DEGLITCH_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
	localparam int SOC_DEGLITCH_CYC = (SOC_DEGLITCH_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
	localparam int OTP_DEGLITCH_CYC = (OTP_DEGLITCH_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
	localparam int NVP_HOLD_CYC = (NVP_HOLD_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
	localparam int DROOP_RETURN_CYC = (DROOP_RETURN_NS * CLK_MHZ) / NS_PER_US;
	localparam int TICK_US_CYC = (TICK_US_NS * CLK_MHZ) / NS_PER_US;
	// stage temperature deglitch choices, ns
	localparam int STAGE_TEMP_SENSE_DEGLITCH_NS [4] = '{1000, 2000, 5000, 20000};

	// ------------------------------------------------------------------
	// analog scaling (sense code lsb 5 mV, temp adc lsb 10 mV)
	// ------------------------------------------------------------------
	localparam int SENSE_LSB_UV = 5000;
	localparam int REF_REL_MIN_MV = 1330;
	localparam logic [9:0] REF_REL_MIN_CODE = 10'(REF_REL_MIN_MV * 1000 / SENSE_LSB_UV);
	localparam int OV_ABS_MV [4] = '{2000, 2100, 2200, 1900};
	localparam logic [4:0] OV_REL_TENTHS [4] = '{5'h0f, 5'h0e, 5'h0d, 5'h10};
	localparam logic [4:0] UV_TENTHS [4] = '{5'h04, 5'h03, 5'h05, 5'h06};
	localparam logic [4:0] TENTHS_DIV = 5'h0a;
	localparam logic [7:0] OTP_DEG_C [4] = '{8'h96, 8'h8c, 8'h82, 8'ha0};
	localparam int STAGE_TEMP_SENSE_LSB_MV = 10;
	localparam int STAGE_TEMP_SENSE_SHUTDOWN_MV = 800;
	localparam logic [7:0] STAGE_TEMP_SENSE_SHUTDOWN_CODE = 8'(STAGE_TEMP_SENSE_SHUTDOWN_MV / STAGE_TEMP_SENSE_LSB_MV);
	// soft-stop slope: 1.5 mV/us is 3 of 10 lsb tenths per us
	localparam logic [3:0] RAMP_TENTHS_PER_US = 4'h3;
	localparam logic [3:0] RAMP_TENTHS_PER_LSB = 4'ha;
	localparam logic [5:0] DROOP_GAIN_DCR [4] = '{6'h30, 6'h18, 6'h0c, 6'h06};
	localparam logic [5:0] DROOP_GAIN_SPS [4] = '{6'h0c, 6'h06, 6'h03, 6'h02};
	localparam int SPS_DIV_SHIFT = 3;
	localparam logic [7:0] DROOP_MAX = 8'hff;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_OVP_ABS = 8'h25;
	localparam logic [7:0] ADDR_OVP_WEIGHT = 8'h26;
	localparam logic [7:0] ADDR_UVP_SEL = 8'h27;
	localparam logic [7:0] ADDR_OTP_SEL = 8'h28;
	localparam logic [7:0] ADDR_PROT_EN = 8'h29;
	localparam logic [7:0] ADDR_FAULT_FLAGS = 8'h2a;
	localparam logic [7:0] ADDR_STAGE_TEMP_SENSE_DEGLITCH = 8'h33;
	localparam logic [7:0] ADDR_DROOP_GAIN = 8'h41;
	localparam logic [7:0] RST_SELECT = 8'h00;
	localparam logic [7:0] RST_PROT_EN = 8'h1f;
	localparam int SEL_LSB = 0;
	localparam int DROOP_GAIN_LSB = 2;
	localparam int FAULT_OV = 0;
	localparam int FAULT_UV = 1;
	localparam int FAULT_SOC = 2;
	localparam int FAULT_OTP = 3;
	localparam int FAULT_STAGE_TEMP_SENSE = 4;
	localparam int FAULT_COUNT = 5;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_SOFTSTART = 3'h1,
		ST_RUN = 3'h2,
		ST_NVP_HOLD = 3'h3,
		ST_SOFTSTOP = 3'h4,
		ST_LATCHED = 3'h5
	} supervisor_state_t;

	typedef enum logic [1:0] {
		PWM_NORMAL = 2'h0,
		PWM_TRISTATE = 2'h1,
		PWM_LOW = 2'h2,
		PWM_LOW_PULSE = 2'h3
	} pwm_mode_t;

endpackage

// *** design/buck_fault_supervisor.sv ***
// fault supervision, power-good and droop target logic of the buck controller
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// deglitch counter: pulses once a condition has held for limit cycles
// ----------------------------------------------------------------------
module fault_deglitch (
	// clock and reset
	input wire logic clock,
	input wire logic rstSync_b,
	// condition and result
	input wire logic cond,
	input wire logic [15:0] limit,
	output logic trip
);
	logic [15:0] count_q;

	assign trip = cond && (count_q == limit - 16'h0001);

	always_ff @(posedge clock or negedge rstSync_b) begin
		if (!rstSync_b) begin
			count_q <= 16'h0000;
		end else if (!cond) begin
			count_q <= 16'h0000;
		end else if (count_q != limit) begin
			count_q <= count_q + 16'h0001;
		end
	end
endmodule // fault_deglitch

// Function
// - power-good low during soft-start
// - release and latch power-good at reference
// - protection trip or enable fall drops power-good
// - absolute overvoltage threshold below 1.33 V
// - relative overvoltage threshold above 1.33 V
// - overvoltage needs 1 us continuous condition
// - overvoltage: power-good low, guard, flag
// - guard: low then regulate for 45 us
// - after 45 us ramp target 1.5 mV/us
// - soft-stop: tristate above target, else low
// - trips latch until enable toggle or power
// - enable bits gate action, never the flag
// - undervoltage 3 us: tristate, discharge, flag
// - undervoltage threshold selectable, default 0.4
// - undervoltage ignored before first power-good
// - die overtemperature 45 us tristates outputs
// - die overtemperature: power-good low, flag
// - stage temperature above 0.8 V, selectable deglitch
// - stage temperature: power-good low, flag
// - load step applies scaled short-term target
// - short-term target returns over 100 us
// - sum overcurrent: tristate, power-good low, flag
module buck_fault_supervisor
	import buck_fault_pkg::*;
#(
	parameter int OTP_CYC = OTP_DEGLITCH_CYC,
	parameter int NVP_CYC = NVP_HOLD_CYC,
	parameter int DROOP_CYC = DROOP_RETURN_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// pins and straps
	input wire logic enablePin,
	input wire logic smartPowerStage,
	// analog front end results, same clock
	input wire logic softStartDone,
	input wire logic [9:0] outputSense,
	input wire logic [9:0] externalReferenceLevel,
	input wire logic [9:0] voltageTargetCode,
	input wire logic [7:0] dieTemperature,
	input wire logic [7:0] stageTempSense,
	input wire logic sumOvercurrentCmp,
	input wire logic loadStep,
	input wire logic [7:0] currentSenseSum,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	output logic [7:0] regRdData,
	// power-good open-drain pin
	input wire logic powerGoodIn,
	output logic powerGoodOut,
	output logic powerGoodOe,
	// power stage control
	output pwm_mode_t pwmMode,
	output logic dischargeSwitch,
	output logic negativeVoltageGuard,
	output logic [9:0] regulationTarget,
	output logic [FAULT_COUNT-1:0] faultFlags
);
	// ------------------------------------------------------------------
	// reset and enable synchronisers
	// ------------------------------------------------------------------
	logic [1:0] rstPipe_q;
	logic rstSync_b;
	logic [2:0] enSync_q;
	logic enable_q;
	logic enAgree;
	logic enRise;
	logic enFall;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rstPipe_q <= 2'h0;
		end else begin
			rstPipe_q <= {rstPipe_q[0], 1'b1};
		end
	end
	assign rstSync_b = rstPipe_q[1];

	always_ff @(posedge clock or negedge rstSync_b) begin
		if (!rstSync_b) begin
			enSync_q <= 3'h0;
			enable_q <= 1'b0;
		end else begin
			enSync_q <= {enSync_q[1:0], enablePin};
			if (enAgree) begin
				enable_q <= enSync_q[2];
			end
		end
	end
	assign enAgree = enSync_q[1] == enSync_q[2];
	assign enRise = enAgree && enSync_q[2] && !enable_q;
	assign enFall = enAgree && !enSync_q[2] && enable_q;

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	logic [7:0] ovAbsSel_q, ovWeightSel_q, uvSel_q, otpSel_q;
	logic [7:0] protEnable_q, tsenDeglitchSel_q, droopGainSel_q;
	logic [FAULT_COUNT-1:0] flags_q;
	logic [7:0] readMux;

	always_ff @(posedge clock or negedge rstSync_b) begin
		if (!rstSync_b) begin
			ovAbsSel_q <= RST_SELECT;
			ovWeightSel_q <= RST_SELECT;
			uvSel_q <= RST_SELECT;
			otpSel_q <= RST_SELECT;
			protEnable_q <= RST_PROT_EN;
			tsenDeglitchSel_q <= RST_SELECT;
			droopGainSel_q <= RST_SELECT;
		end else if (regWrEn) begin
			case (regAddr)
				ADDR_OVP_ABS: ovAbsSel_q <= regWrData;
				ADDR_OVP_WEIGHT: ovWeightSel_q <= regWrData;
				ADDR_UVP_SEL: uvSel_q <= regWrData;
				ADDR_OTP_SEL: otpSel_q <= regWrData;
				ADDR_PROT_EN: protEnable_q <= regWrData;
				ADDR_STAGE_TEMP_SENSE_DEGLITCH: tsenDeglitchSel_q <= regWrData;
				ADDR_DROOP_GAIN: droopGainSel_q <= regWrData;
				default: ;
			endcase
		end
	end

	assign readMux = (regAddr == ADDR_OVP_ABS) ? ovAbsSel_q :
		(regAddr == ADDR_OVP_WEIGHT) ? ovWeightSel_q :
		(regAddr == ADDR_UVP_SEL) ? uvSel_q :
		(regAddr == ADDR_OTP_SEL) ? otpSel_q :
		(regAddr == ADDR_PROT_EN) ? protEnable_q :
		(regAddr == ADDR_FAULT_FLAGS) ? {3'h0, flags_q} :
		(regAddr == ADDR_STAGE_TEMP_SENSE_DEGLITCH) ? tsenDeglitchSel_q :
		(regAddr == ADDR_DROOP_GAIN) ? droopGainSel_q : 8'h00;

	// ------------------------------------------------------------------
	// fault conditions
	// ------------------------------------------------------------------
	logic [1:0] ovAbsIdx, ovWeightIdx, uvIdx, otpIdx, tsenIdx, gainIdx;
	logic absMode;
	logic [9:0] ovAbsCode;
	logic [13:0] senseTenths, ovRelLimit, uvLimit;
	logic pgoodSeen_q;
	logic ovCond, uvCond, socCond, otpCond, tsenCond;
	logic [15:0] tsenLimit;
	logic [FAULT_COUNT-1:0] trips;
	logic [FAULT_COUNT-1:0] actions;
	logic shutdownAction;

	assign ovAbsIdx = ovAbsSel_q[SEL_LSB +: 2];
	assign ovWeightIdx = ovWeightSel_q[SEL_LSB +: 2];
	assign uvIdx = uvSel_q[SEL_LSB +: 2];
	assign otpIdx = otpSel_q[SEL_LSB +: 2];
	assign tsenIdx = tsenDeglitchSel_q[SEL_LSB +: 2];
	assign gainIdx = droopGainSel_q[DROOP_GAIN_LSB +: 2];

	assign absMode = externalReferenceLevel < REF_REL_MIN_CODE;
	assign ovAbsCode = 10'(OV_ABS_MV[ovAbsIdx] * 1000 / SENSE_LSB_UV);
	assign senseTenths = outputSense * TENTHS_DIV;
	assign ovRelLimit = externalReferenceLevel * OV_REL_TENTHS[ovWeightIdx];
	assign uvLimit = externalReferenceLevel * UV_TENTHS[uvIdx];
	assign ovCond = enable_q && (absMode ? outputSense > ovAbsCode : senseTenths > ovRelLimit);
	assign uvCond = enable_q && pgoodSeen_q && senseTenths < uvLimit;
	assign socCond = enable_q && sumOvercurrentCmp;
	assign otpCond = enable_q && dieTemperature > OTP_DEG_C[otpIdx];
	assign tsenCond = enable_q && stageTempSense > STAGE_TEMP_SENSE_SHUTDOWN_CODE;
	assign tsenLimit = 16'(STAGE_TEMP_SENSE_DEGLITCH_NS[tsenIdx] * CLK_MHZ / NS_PER_US);

	fault_deglitch ovGlitch (.clock(clock), .rstSync_b(rstSync_b), .cond(ovCond),
		.limit(16'(OV_DEGLITCH_CYC)), .trip(trips[FAULT_OV]));
	fault_deglitch uvGlitch (.clock(clock), .rstSync_b(rstSync_b), .cond(uvCond),
		.limit(16'(UV_DEGLITCH_CYC)), .trip(trips[FAULT_UV]));
	fault_deglitch socGlitch (.clock(clock), .rstSync_b(rstSync_b), .cond(socCond),
		.limit(16'(SOC_DEGLITCH_CYC)), .trip(trips[FAULT_SOC]));
	fault_deglitch otpGlitch (.clock(clock), .rstSync_b(rstSync_b), .cond(otpCond),
		.limit(16'(OTP_CYC)), .trip(trips[FAULT_OTP]));
	fault_deglitch tsenGlitch (.clock(clock), .rstSync_b(rstSync_b), .cond(tsenCond),
		.limit(tsenLimit), .trip(trips[FAULT_STAGE_TEMP_SENSE]));

	// flag is always set, action only when enabled
	assign actions = trips & protEnable_q[FAULT_COUNT-1:0];
	assign shutdownAction = |actions[FAULT_STAGE_TEMP_SENSE:FAULT_UV];

	// set wins over the clear on enable re-assertion
	always_ff @(posedge clock or negedge rstSync_b) begin
		if (!rstSync_b) begin
			flags_q <= '0;
		end else begin
			flags_q <= (enRise ? '0 : flags_q) | trips;
		end
	end

	// ------------------------------------------------------------------
	// supervisor state machine
	// ------------------------------------------------------------------
	supervisor_state_t state_q, stateD;
	logic [15:0] nvpCount_q;
	logic nvpDone;
	logic [9:0] rampCode_q;
	logic [3:0] rampFrac_q;
	logic [7:0] tickCount_q;
	logic usTick;
	logic reachedRef;

	assign reachedRef = softStartDone && outputSense >= externalReferenceLevel;
	assign nvpDone = nvpCount_q == 16'(NVP_CYC - 1);
	assign usTick = tickCount_q == 8'(TICK_US_CYC - 1);

	always_comb begin
		stateD = state_q;
		case (state_q)
			ST_OFF: if (enable_q) stateD = ST_SOFTSTART;
			ST_SOFTSTART, ST_RUN: begin
				if (state_q == ST_SOFTSTART && reachedRef) stateD = ST_RUN;
				if (actions[FAULT_OV]) stateD = ST_NVP_HOLD;
			end
			ST_NVP_HOLD: if (nvpDone) stateD = ST_SOFTSTOP;
			ST_SOFTSTOP, ST_LATCHED: stateD = state_q;
			default: stateD = ST_OFF;
		endcase
		if (shutdownAction && state_q != ST_OFF) stateD = ST_LATCHED;
		if (!enable_q || enFall) stateD = ST_OFF;
	end

	always_ff @(posedge clock or negedge rstSync_b) begin
		if (!rstSync_b) begin
			state_q <= ST_OFF;
			pgoodSeen_q <= 1'b0;
		end else begin
			state_q <= stateD;
			pgoodSeen_q <= (stateD == ST_RUN) || (pgoodSeen_q && stateD != ST_OFF);
		end
	end

	// 45 us guard timer and 1 us ramp tick
	always_ff @(posedge clock or negedge rstSync_b) begin
		if (!rstSync_b) begin
			nvpCount_q <= 16'h0000;
			tickCount_q <= 8'h00;
		end else begin
			nvpCount_q <= (state_q == ST_NVP_HOLD) ? nvpCount_q + 16'h0001 : 16'h0000;
			tickCount_q <= usTick ? 8'h00 : tickCount_q + 8'h01;
		end
	end

	// soft-stop ramp in tenths of an lsb per us
	always_ff @(posedge clock or negedge rstSync_b) begin
		if (!rstSync_b) begin
			rampCode_q <= 10'h000;
			rampFrac_q <= 4'h0;
		end else if (state_q != ST_SOFTSTOP) begin
			rampCode_q <= voltageTargetCode;
			rampFrac_q <= 4'h0;
		end else if (usTick && rampCode_q != 10'h000) begin
			if (rampFrac_q + RAMP_TENTHS_PER_US >= RAMP_TENTHS_PER_LSB) begin
				rampFrac_q <= rampFrac_q + RAMP_TENTHS_PER_US - RAMP_TENTHS_PER_LSB;
				rampCode_q <= rampCode_q - 10'h001;
			end else begin
				rampFrac_q <= rampFrac_q + RAMP_TENTHS_PER_US;
			end
		end
	end

	// ------------------------------------------------------------------
	// short-term droop target
	// ------------------------------------------------------------------
	logic [13:0] droopProduct;
	logic [13:0] droopScaled;
	logic [7:0] droopOffset_q;
	logic [15:0] droopTick_q;
	logic droopStep;
	logic [9:0] droopTarget;

	assign droopProduct = currentSenseSum *
		(smartPowerStage ? DROOP_GAIN_SPS[gainIdx] : DROOP_GAIN_DCR[gainIdx]);
	assign droopScaled = smartPowerStage ? droopProduct >> SPS_DIV_SHIFT : droopProduct;
	assign droopStep = droopTick_q == 16'(DROOP_CYC / 256 - 1);
	assign droopTarget = (voltageTargetCode > 10'(droopOffset_q)) ?
		voltageTargetCode - 10'(droopOffset_q) : 10'h000;

	always_ff @(posedge clock or negedge rstSync_b) begin
		if (!rstSync_b) begin
			droopOffset_q <= 8'h00;
			droopTick_q <= 16'h0000;
		end else if (loadStep && state_q == ST_RUN) begin
			droopOffset_q <= (droopScaled > 14'(DROOP_MAX)) ? DROOP_MAX : droopScaled[7:0];
			droopTick_q <= 16'h0000;
		end else if (state_q != ST_RUN) begin
			droopOffset_q <= 8'h00;
		end else begin
			droopTick_q <= droopStep ? 16'h0000 : droopTick_q + 16'h0001;
			if (droopStep && droopOffset_q != 8'h00) begin
				droopOffset_q <= droopOffset_q - 8'h01;
			end
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	pwm_mode_t pwmD;
	logic [9:0] targetD;

	always_comb begin
		pwmD = PWM_TRISTATE;
		targetD = droopTarget;
		case (stateD)
			ST_SOFTSTART, ST_RUN: pwmD = PWM_NORMAL;
			ST_NVP_HOLD: begin
				targetD = voltageTargetCode;
				pwmD = (outputSense > voltageTargetCode) ? PWM_LOW : PWM_LOW_PULSE;
			end
			ST_SOFTSTOP: begin
				targetD = rampCode_q;
				pwmD = (outputSense > rampCode_q) ? PWM_TRISTATE : PWM_LOW;
			end
			default: pwmD = PWM_TRISTATE;
		endcase
	end

	always_ff @(posedge clock or negedge rstSync_b) begin
		if (!rstSync_b) begin
			regRdData <= 8'h00;
			powerGoodOut <= 1'b0;
			powerGoodOe <= 1'b1;
			pwmMode <= PWM_TRISTATE;
			dischargeSwitch <= 1'b0;
			negativeVoltageGuard <= 1'b0;
			regulationTarget <= 10'h000;
			faultFlags <= '0;
		end else begin
			regRdData <= readMux;
			powerGoodOe <= stateD != ST_RUN;
			pwmMode <= pwmD;
			dischargeSwitch <= actions[FAULT_UV] || (dischargeSwitch && stateD != ST_OFF);
			negativeVoltageGuard <= stateD == ST_NVP_HOLD || stateD == ST_SOFTSTOP;
			regulationTarget <= targetD;
			faultFlags <= (enRise ? '0 : flags_q) | trips;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstSync_b);

	a_power_good_out_softstart: assert property (state_q == ST_SOFTSTART |-> powerGoodOe)
		else $error("power-good released during soft-start");
	a_power_good_out_release: assert property (state_q == ST_SOFTSTART && reachedRef && enable_q
		&& !enFall && actions == '0 |=> !powerGoodOe && state_q == ST_RUN)
		else $error("power-good not released at reference");
	a_power_good_out_trip: assert property (state_q == ST_RUN && (actions != '0 || enFall)
		|=> powerGoodOe)
		else $error("power-good held high after trip");
	a_ov_deglitch: assert property ($rose(ovCond) |-> !trips[FAULT_OV] [*8])
		else $error("overvoltage tripped without deglitch");
	a_ov_guard: assert property (actions[FAULT_OV] && state_q == ST_RUN && enable_q
		&& !enFall && !shutdownAction |=> negativeVoltageGuard && faultFlags[FAULT_OV])
		else $error("overvoltage guard or flag missing");
	a_softstop_entry: assert property (state_q == ST_NVP_HOLD && nvpDone && enable_q
		&& !enFall && !shutdownAction |=> state_q == ST_SOFTSTOP)
		else $error("soft-stop not entered after guard time");
	a_flag_sticky: assert property (!enRise |=> (flags_q & $past(flags_q)) == $past(flags_q))
		else $error("fault flag lost without enable toggle");
	a_flag_disabled: assert property (trips[FAULT_STAGE_TEMP_SENSE] && !protEnable_q[FAULT_STAGE_TEMP_SENSE]
		|=> flags_q[FAULT_STAGE_TEMP_SENSE])
		else $error("disabled fault did not set its flag");
	a_uv_mask: assert property (!pgoodSeen_q |-> !trips[FAULT_UV])
		else $error("undervoltage detected before power-good");
	a_uv_action: assert property (actions[FAULT_UV] && enable_q && !enFall
		|=> pwmMode == PWM_TRISTATE && dischargeSwitch)
		else $error("undervoltage action missing");

	c_ov_softstop: cover property (state_q == ST_NVP_HOLD ##1 state_q == ST_SOFTSTOP);
	c_uv_latched: cover property (actions[FAULT_UV] ##1 state_q == ST_LATCHED);
	c_power_good_out_up: cover property (state_q == ST_SOFTSTART ##1 state_q == ST_RUN);
	c_droop_load: cover property (loadStep && state_q == ST_RUN ##1 droopOffset_q != 8'h00);
endmodule // buck_fault_supervisor

// *** test/stage_model.sv ***
// output node and power-good pull-up standing in for the power stages
`timescale 1ns/100ps
module stage_model (
	// clock
	input wire logic clock,
	// stage controls
	input wire logic [9:0] level,
	input wire logic dischargeSwitch,
	input wire logic powerGoodOe,
	// node and pin
	output logic [9:0] outputSense,
	output logic powerGoodIn
);
	logic [9:0] drop = 10'h000;
	// closed switch bleeds the node down
	always @(posedge clock) drop <= dischargeSwitch ? drop + 10'h001 : 10'h000;
	assign outputSense = (level > drop) ? level - drop : 10'h000;
	// pull-up when released
	assign powerGoodIn = powerGoodOe ? 1'b0 : 1'b1;
endmodule // stage_model

// *** test/test_buck_fault_supervisor.sv ***
// self-checking bench of the buck fault supervisor
`timescale 1ns/100ps
module test_buck_fault_supervisor;
	import buck_fault_pkg::*;
	localparam int NEGATIVE_VOLTAGE_GUARD = 50;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic enablePin = 1'b0;
	logic smartPowerStage = 1'b0;
	logic softStartDone = 1'b0;
	logic sumOvercurrentCmp = 1'b0;
	logic loadStep = 1'b0;
	logic regWrEn = 1'b0;
	logic [9:0] level = 10'h000;
	logic [9:0] externalReferenceLevel = 10'h0c8;
	logic [9:0] voltageTargetCode = 10'h0c8;
	logic [9:0] outputSense, regulationTarget;
	logic [7:0] dieTemperature = 8'h19;
	logic [7:0] stageTempSense = 8'h10;
	logic [7:0] currentSenseSum = 8'h00;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic [7:0] regRdData;
	logic powerGoodIn, powerGoodOut, powerGoodOe, dischargeSwitch, negativeVoltageGuard;
	pwm_mode_t pwmMode;
	logic [FAULT_COUNT-1:0] faultFlags;
	logic [7:0] addrs [8] = '{ADDR_OVP_ABS, ADDR_OVP_WEIGHT, ADDR_UVP_SEL, ADDR_OTP_SEL,
		ADDR_PROT_EN, ADDR_FAULT_FLAGS, ADDR_STAGE_TEMP_SENSE_DEGLITCH, ADDR_DROOP_GAIN};
	int n_fail = 0;
	int n_tests = 0;
	int thr, s, lim;
	always #2.5 clock = ~clock;

	buck_fault_supervisor #(.OTP_CYC(50), .NVP_CYC(NEGATIVE_VOLTAGE_GUARD), .DROOP_CYC(512)) i_buck_fault_supervisor (
		.clock, .rst_b, .enablePin, .smartPowerStage, .softStartDone, .outputSense,
		.externalReferenceLevel, .voltageTargetCode, .dieTemperature, .stageTempSense,
		.sumOvercurrentCmp, .loadStep, .currentSenseSum, .regAddr, .regWrData, .regWrEn,
		.regRdData, .powerGoodIn, .powerGoodOut, .powerGoodOe, .pwmMode, .dischargeSwitch,
		.negativeVoltageGuard, .regulationTarget, .faultFlags);
	stage_model i_stage_model (.clock, .level, .dischargeSwitch, .powerGoodOe, .outputSense,
		.powerGoodIn);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic chk(input logic [9:0] got, input int exp);
		n_tests++;
		if (got !== 10'(exp)) begin
			n_fail++;
			$display("[ERR] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		tick(1);
		regWrEn = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input int exp);
		regAddr = a;
		tick(2);
		chk(10'(regRdData), exp);
	endtask
	task automatic setCond(input int f, input logic on);
		sumOvercurrentCmp = on && f == FAULT_SOC;
		dieTemperature = (on && f == FAULT_OTP) ? 8'h97 : 8'h19;
		stageTempSense = (on && f == FAULT_STAGE_TEMP_SENSE) ? 8'h51 : 8'($urandom % 80);
	endtask
	task automatic bringUp();
		enablePin = 1'b0;
		softStartDone = 1'b0;
		setCond(0, 1'b0);
		level = 10'h000;
		tick(8);
		chk(10'(powerGoodOe), 1);
		enablePin = 1'b1;
		tick(650);
		chk(10'(faultFlags), 0);
		level = externalReferenceLevel;
		tick(4);
		chk(10'(powerGoodOe), 1);
		softStartDone = 1'b1;
		for (int k = 0; k < 20 && powerGoodOe !== 1'b0; k++) tick(1);
		chk(10'(powerGoodOe), 0);
		level = externalReferenceLevel - 10'h001;
		tick(4);
		chk(10'(powerGoodOe), 0);
	endtask
	// hold a condition just short of and just past its deglitch count
	task automatic edgeOf(input int n, input int flags);
		tick(n - 2);
		chk(10'(faultFlags), 0);
		tick(5);
		chk(10'(faultFlags), flags);
	endtask
	task automatic final_report();
		if (n_fail == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		#300000;
		n_fail++;
		final_report();
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(32'hc997));
		tick(8);
		rst_b = 1'b1;
		tick(4);
		foreach (addrs[i]) rd(addrs[i], (addrs[i] == ADDR_PROT_EN) ? 32'(RST_PROT_EN) : 0);
		rd(8'h30, 0);
		wr(ADDR_FAULT_FLAGS, 8'hff);
		rd(ADDR_FAULT_FLAGS, 0);
		s = $urandom % 256;
		wr(ADDR_OTP_SEL, 8'(s));
		rd(ADDR_OTP_SEL, s);
		wr(ADDR_OTP_SEL, RST_SELECT);
		for (int a = 0; a < 4; a++) begin
			wr(ADDR_OVP_ABS, 8'(a));
			bringUp();
			thr = OV_ABS_MV[a] / 5;
			level = 10'(thr);
			tick(300);
			chk(10'(faultFlags), 0);
			level = 10'(thr + 1);
			tick(150);
			level = externalReferenceLevel;
			tick(1);
			level = 10'(thr + 1);
			edgeOf(200, 1);
			chk(10'(negativeVoltageGuard), 1);
			chk(10'(powerGoodOe), 1);
			chk(10'(pwmMode inside {PWM_LOW, PWM_LOW_PULSE}), 1);
		end
		tick(NEGATIVE_VOLTAGE_GUARD + 10);
		chk(10'(pwmMode), PWM_TRISTATE);
		tick(1400);
		chk(10'((voltageTargetCode - regulationTarget) inside {[1:3]}), 1);
		level = 10'h000;
		tick(3);
		chk(10'(pwmMode), PWM_LOW);
		externalReferenceLevel = 10'h12c;
		s = $urandom % 4;
		wr(ADDR_OVP_WEIGHT, 8'(s));
		bringUp();
		thr = 30 * OV_REL_TENTHS[s];
		level = 10'(thr);
		tick(300);
		chk(10'(faultFlags), 0);
		level = 10'(thr + 1);
		edgeOf(200, 1);
		externalReferenceLevel = 10'h0c8;
		for (int i = 0; i < 2; i++) begin
			s = i ? $urandom % 4 : 0;
			wr(ADDR_UVP_SEL, 8'(s));
			bringUp();
			thr = 20 * UV_TENTHS[s];
			level = 10'(thr);
			tick(650);
			chk(10'(faultFlags), 0);
			level = 10'(thr - 1);
			edgeOf(600, 2);
			chk(10'(pwmMode), PWM_TRISTATE);
			chk(10'(dischargeSwitch), 1);
			chk(10'(powerGoodOe), 1);
		end
		s = $urandom % 4;
		wr(ADDR_STAGE_TEMP_SENSE_DEGLITCH, 8'(s));
		for (int f = FAULT_SOC; f <= FAULT_STAGE_TEMP_SENSE; f++) begin
			for (int en = 0; en < 2; en++) begin
				wr(ADDR_PROT_EN, en ? RST_PROT_EN : RST_PROT_EN & ~(8'h01 << f));
				bringUp();
				lim = (f == FAULT_OTP) ? 50 : (f == FAULT_STAGE_TEMP_SENSE) ? STAGE_TEMP_SENSE_DEGLITCH_NS[s] / 5 : 200;
				setCond(f, 1'b1);
				edgeOf(lim, 1 << f);
				setCond(f, 1'b0);
				tick(3);
				rd(ADDR_FAULT_FLAGS, 1 << f);
				chk(10'(powerGoodOe), en);
				chk(10'(pwmMode), en ? PWM_TRISTATE : PWM_NORMAL);
			end
		end
		voltageTargetCode = 10'h200;
		for (int p = 0; p < 2; p++) begin
			smartPowerStage = p[0];
			wr(ADDR_DROOP_GAIN, 8'(p + 1) << DROOP_GAIN_LSB);
			bringUp();
			currentSenseSum = 8'($urandom % 256);
			thr = p ? (currentSenseSum * 3) >> 3 : currentSenseSum * 24;
			thr = (thr > 255) ? 255 : thr;
			loadStep = 1'b1;
			tick(1);
			loadStep = 1'b0;
			tick(1);
			chk(10'((voltageTargetCode - regulationTarget) inside {[thr - 1:thr]}), 1);
			tick(2 * thr + 20);
			chk(regulationTarget, voltageTargetCode);
		end
		final_report();
	end
endmodule // test_buck_fault_supervisor
